// File: rtl/cpm_top.sv
// Clock generation and power-mode sequencing with an APB register port.
// Assumes ref_tick is a 32 MHz enable on pclk and the core signals
// wait and stop instructions as one-cycle pulses on pclk.
//
// Operation
// - Processor, bus and peripheral enables derive from the 32 MHz reference tick.
// - Bus clock runs at half the processor clock rate in both run modes.
// - Each peripheral has its own software clock gate.
// - Run mode clocks processor at full speed, regulation fully on.
// - Low-power run gives 500 kHz processor, 250 kHz bus, regulator standby.
// - Wait halts processor clock; system clocks and regulation stay on.
// - Low-power wait halts processor, bus at 250 kHz, regulator standby.
// - Stop halts all system clocks with regulator in standby.
// - Third stop level keeps circuits powered; software picks oscillator on/off.
// - Halt and wait instructions start the matching power-mode sequence.
// - Radio powered only while transmit, receive or CCA/ED runs.
// - Keypad, serial receive and wake timer can wake the device.
// - Wake counter may run from the optional 32.768 kHz crystal.
// - Internal 1 kHz oscillator times wake-up from sleep.
// - Watchdog clock selectable: dedicated internal source or bus clock.
//
// Added by the designer: register access over APB and the register offsets.
`timescale 1ns/1ps
module cpm_top
  import cpm_pkg::*;
#(
  parameter int NP = NPERIPH
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [cpm_pkg::AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Reference and processor
  input wire logic ref_tick,
  input wire logic cpu_wait_instr,
  input wire logic cpu_stop_instr,
  input wire logic irq_pending,
  // Asynchronous pins
  input wire logic keypad_interrupt_unit_req,
  input wire logic serial_rxd,
  input wire logic xtal32k_clk,
  input wire logic osc1k_clk,
  // Radio activity
  input wire logic radio_tx_busy,
  input wire logic radio_rx_busy,
  input wire logic radio_cca_busy,
  // Clock and power outputs
  output cpm_pkg::cpm_clk_t clk_en,
  output logic [NP-1:0] periph_clk_en,
  output logic watchdog_monitor_clk_en,
  output logic regulator_standby,
  output logic ref_osc_enable,
  output logic cpu_halted,
  output logic radio_power_en
);
  import cpm_pkg::*;

  localparam logic [7:0] SETTLE_LOAD = 8'(SETTLE_CYC - 1);

  cpm_ctrl_t ctrl;
  logic [NP-1:0] gate;
  logic [WMOD_W-1:0] wake_mod;
  logic [WMOD_W-1:0] wake_cnt;
  logic [WSRC_W-1:0] wake_src;
  cpm_state_t state;
  cpm_state_t next_state;
  logic [7:0] settle_cnt;
  logic [3:0] sync1;
  logic [3:0] sync2;
  logic [3:0] sync3;
  logic kbd_lvl;
  logic rxd_fall;
  logic t32k_tick;
  logic t1k_tick;
  logic lp_tick;
  logic lp_active;
  logic clocks_on;
  logic src_tick;
  logic src_q;
  logic cpu_en_q;
  logic bus_tick;
  logic tmr_tick;
  logic tmr_wake;
  logic kbd_wake;
  logic ser_wake;
  logic any_wake;
  logic setup;
  logic wr_en;
  logic hit;
  logic [31:0] rdata;
  logic [WSRC_W-1:0] wsrc_set;
  logic [WSRC_W-1:0] wsrc_clr;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  // Two flops per pin; a third only feeds the edge detectors
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1 <= 4'h0;
      sync2 <= 4'h0;
      sync3 <= 4'h0;
    end
    else
    begin
      sync1 <= {osc1k_clk, xtal32k_clk, serial_rxd, keypad_interrupt_unit_req};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  assign kbd_lvl = sync2[0];
  assign rxd_fall = sync3[1] & ~sync2[1]; // start bit edge
  assign t32k_tick = sync2[2] & ~sync3[2];
  assign t1k_tick = sync2[3] & ~sync3[3];

  // ****************************************************************
  // Clock enable generation
  // ****************************************************************
  // Low-power rate from the reference, never from pclk
  cpm_tick_div #(
    .DIV(LP_DIV)
  ) u_lp_div (
    .clk(pclk),
    .rst_n(presetn),
    .clr(1'b0),
    .tick_in(ref_tick),
    .tick_out(lp_tick)
  );

  // Low-power rate applies in low-power run and low-power wait
  assign lp_active = (state == ST_RUN) ? ctrl.lp_run : (ctrl.lp_wait | ctrl.lp_run);
  assign clocks_on = (state == ST_RUN) || (state == ST_WAIT);
  assign src_tick = clocks_on & (lp_active ? lp_tick : ref_tick);

  // Processor tick only in run; wait keeps the rest going
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      src_q <= 1'b0;
      cpu_en_q <= 1'b0;
    end
    else
    begin
      src_q <= src_tick;
      cpu_en_q <= src_tick && (state == ST_RUN);
    end
  end

  // Bus is every second source tick; stop clears the phase
  cpm_tick_div #(
    .DIV(BUS_DIV)
  ) u_bus_div (
    .clk(pclk),
    .rst_n(presetn),
    .clr(!clocks_on),
    .tick_in(src_tick),
    .tick_out(bus_tick)
  );

  assign clk_en.cpu_en = cpu_en_q;
  assign clk_en.bus_en = bus_tick;

  // Per-peripheral gating of the bus enable
  cpm_clk_gate #(
    .W(NP)
  ) u_gate (
    .en(bus_tick),
    .mask(gate),
    .en_out(periph_clk_en)
  );

  // Watchdog source select; internal source runs even in stop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      watchdog_monitor_clk_en <= 1'b0;
    else
      watchdog_monitor_clk_en <= ctrl.wdog_bus ? bus_tick : t1k_tick;
  end

  // ****************************************************************
  // Wake sources
  // ****************************************************************
  // Timer runs from 1 kHz by default or the 32.768 kHz crystal
  assign tmr_tick = ctrl.tmr_src_32k ? t32k_tick : t1k_tick;
  assign tmr_wake = ctrl.tmr_wake_en && tmr_tick && (wake_cnt == wake_mod);
  assign kbd_wake = ctrl.kbd_wake_en && kbd_lvl;
  assign ser_wake = ctrl.ser_wake_en && rxd_fall;
  assign any_wake = tmr_wake | kbd_wake | ser_wake;

  // Counter only advances while asleep so each sleep gets a full period
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      wake_cnt <= '0;
    else if (state == ST_RUN || !ctrl.tmr_wake_en || tmr_wake)
      wake_cnt <= '0;
    else if (tmr_tick && (state == ST_WAIT || state == ST_STOP))
      wake_cnt <= wake_cnt + 1'b1;
  end

  // ****************************************************************
  // Power-mode sequencer
  // ****************************************************************
  // Instructions only count in run; wake ends wait or stop
  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_RUN:
      begin
        if (cpu_stop_instr)
          next_state = ST_STOP;
        else if (cpu_wait_instr)
          next_state = ST_WAIT;
      end
      ST_WAIT:
      begin
        if (irq_pending || any_wake)
          next_state = ST_RUN;
      end
      ST_STOP:
      begin
        if (any_wake)
          next_state = ST_SETTLE;
      end
      ST_SETTLE:
      begin
        if (settle_cnt == 8'h00)
          next_state = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state <= ST_RUN;
    else
      state <= next_state;
  end

  // Settle time covers oscillator restart before the core resumes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      settle_cnt <= 8'h00;
    else if (state == ST_STOP)
      settle_cnt <= SETTLE_LOAD;
    else if (state == ST_SETTLE && settle_cnt != 8'h00)
      settle_cnt <= settle_cnt - 8'h01;
  end

  // Mode-dependent power controls
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      regulator_standby <= 1'b0;
      ref_osc_enable <= 1'b1;
      cpu_halted <= 1'b0;
    end
    else
    begin
      regulator_standby <= (next_state == ST_STOP) || (next_state != ST_SETTLE && lp_active);
      ref_osc_enable <= (next_state != ST_STOP) || ctrl.keep_osc;
      cpu_halted <= (next_state != ST_RUN);
    end
  end

  // Radio follows the live activity flags
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      radio_power_en <= 1'b0;
    else
      radio_power_en <= radio_tx_busy | radio_rx_busy | radio_cca_busy;
  end

  // ****************************************************************
  // APB registers
  // ****************************************************************
  // Zero wait states; read data captured in the setup cycle
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pwrite;
  assign hit = (paddr == CTRL_OFF) || (paddr == GATE_OFF) || (paddr == STAT_OFF) || (paddr == WMOD_OFF);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl <= CTRL_RST;
      gate <= GATE_RST;
      wake_mod <= WMOD_RST;
    end
    else if (wr_en)
    begin
      if (paddr == CTRL_OFF)
        ctrl <= pwdata[7:0];
      if (paddr == GATE_OFF)
        gate <= pwdata[NP-1:0];
      if (paddr == WMOD_OFF)
        wake_mod <= pwdata[WMOD_W-1:0];
    end
  end

  // Sticky wake sources, write one to clear; a new wake wins
  assign wsrc_set = {(state != ST_RUN) & tmr_wake, (state != ST_RUN) & ser_wake, (state != ST_RUN) & kbd_wake};
  assign wsrc_clr = (wr_en && paddr == STAT_OFF) ? pwdata[STAT_WSRC_LSB +: WSRC_W] : '0;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      wake_src <= '0;
    else
      wake_src <= (wake_src & ~wsrc_clr) | wsrc_set;
  end

  // Read mux
  always_comb
  begin
    rdata = 32'h0000_0000;
    if (paddr == CTRL_OFF)
      rdata[7:0] = ctrl;
    else if (paddr == GATE_OFF)
      rdata[NP-1:0] = gate;
    else if (paddr == STAT_OFF)
    begin
      rdata[STAT_STATE_LSB +: 2] = state;
      rdata[STAT_LP_BIT] = lp_active;
      rdata[STAT_RADIO_BIT] = radio_power_en;
      rdata[STAT_WSRC_LSB +: WSRC_W] = wake_src;
    end
    else if (paddr == WMOD_OFF)
      rdata[WMOD_W-1:0] = wake_mod;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (setup && !pwrite)
      prdata <= rdata;
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_bus_half_rate: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en.bus_en |-> src_q && !$past(bus_tick))
    else $error("bus enable not on every second source tick");

  a_cpu_run_only: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en.cpu_en |-> $past(state) == ST_RUN)
    else $error("processor tick outside run mode");

  a_stop_no_clk: assert property (@(posedge pclk) disable iff (!presetn)
    (state == ST_STOP) [*2] |-> !clk_en.bus_en && !clk_en.cpu_en && regulator_standby)
    else $error("clocks or regulation active in stop");

  a_lp_source: assert property (@(posedge pclk) disable iff (!presetn)
    src_q |-> ($past(lp_active) ? $past(lp_tick) : $past(ref_tick)))
    else $error("source tick from wrong rate");

  a_wait_entry: assert property (@(posedge pclk) disable iff (!presetn)
    state == ST_RUN && cpu_wait_instr && !cpu_stop_instr |=> state == ST_WAIT && cpu_halted)
    else $error("wait instruction did not halt processor");

  a_radio_power: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(radio_rx_busy) |=> radio_power_en)
    else $error("radio not powered for receive");

  a_radio_off: assert property (@(posedge pclk) disable iff (!presetn)
    !(radio_tx_busy || radio_rx_busy || radio_cca_busy) |=> !radio_power_en)
    else $error("radio powered while idle");

  a_settle_len: assert property (@(posedge pclk) disable iff (!presetn)
    state == ST_STOP && next_state == ST_SETTLE |=> ##(SETTLE_CYC) state == ST_RUN)
    else $error("settle period length wrong");

  a_osc_keep: assert property (@(posedge pclk) disable iff (!presetn)
    state == ST_STOP && $past(state) == ST_STOP && !ref_osc_enable |-> !$past(ctrl.keep_osc))
    else $error("oscillator off although kept");

  a_wdog_select: assert property (@(posedge pclk) disable iff (!presetn)
    watchdog_monitor_clk_en |-> ($past(ctrl.wdog_bus) ? $past(bus_tick) : $past(t1k_tick)))
    else $error("watchdog enable from wrong source");

endmodule // cpm_top

// File: rtl/cpm_pkg.sv
// Package for the clock and power-mode controller.
// Assumes a 40 MHz pclk and a 32 MHz reference tick from the oscillator interface.
package cpm_pkg;

  // ****************************************************************
  // Clock rates and timing
  // ****************************************************************
  localparam int REF_HZ = 32_000_000;
  localparam int LP_CPU_HZ = 500_000;
  localparam int LP_DIV = REF_HZ / LP_CPU_HZ;
  localparam int BUS_DIV = 2;
  localparam int CLK_MHZ = 40;
  localparam int SETTLE_NS = 2000;
  localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int NPERIPH = 8;
  localparam int AW = 8;
  localparam int WMOD_W = 16;

  // ****************************************************************
  // Register map and reset values
  // ****************************************************************
  localparam logic [AW-1:0] CTRL_OFF = 8'h00;
  localparam logic [AW-1:0] GATE_OFF = 8'h04;
  localparam logic [AW-1:0] STAT_OFF = 8'h08;
  localparam logic [AW-1:0] WMOD_OFF = 8'h0c;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [NPERIPH-1:0] GATE_RST = 8'hff;
  localparam logic [WMOD_W-1:0] WMOD_RST = 16'h03e8;

  // Status field positions
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_LP_BIT = 2;
  localparam int STAT_RADIO_BIT = 3;
  localparam int STAT_WSRC_LSB = 4;
  localparam int WSRC_W = 3;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic ser_wake_en;
    logic kbd_wake_en;
    logic tmr_wake_en;
    logic tmr_src_32k;
    logic wdog_bus;
    logic keep_osc;
    logic lp_wait;
    logic lp_run;
  } cpm_ctrl_t;

  typedef struct packed {
    logic cpu_en;
    logic bus_en;
  } cpm_clk_t;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_WAIT = 2'b01,
    ST_STOP = 2'b10,
    ST_SETTLE = 2'b11
  } cpm_state_t;

endpackage

// File: rtl/cpm_tick_div.sv
// Enable-pulse divider: one output pulse per DIV input pulses.
// Assumes tick_in is a one-cycle enable on the same clock.
`timescale 1ns/1ps
module cpm_tick_div #(
  parameter int DIV = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Ticks
  input wire logic clr,
  input wire logic tick_in,
  output logic tick_out
);
  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);
  logic [CW-1:0] cnt;

  // Count input ticks; clear realigns the phase
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt <= '0;
      tick_out <= 1'b0;
    end
    else
    begin
      tick_out <= tick_in && !clr && (cnt == LAST);
      if (clr)
        cnt <= '0;
      else if (tick_in)
        cnt <= (cnt == LAST) ? '0 : cnt + 1'b1;
    end
  end
endmodule // cpm_tick_div

// File: rtl/cpm_clk_gate.sv
// Per-peripheral clock gate on the bus enable pulse.
// Assumes en is registered upstream, so the gated pulses stay glitch free.
`timescale 1ns/1ps
module cpm_clk_gate #(
  parameter int W = 8
) (
  // Shared enable and mask
  input wire logic en,
  input wire logic [W-1:0] mask,
  // Gated enables
  output logic [W-1:0] en_out
);
  // Each bit passes the pulse only when its mask bit is set
  assign en_out = mask & {W{en}};
endmodule // cpm_clk_gate

// File: sim/cpm_core_model.sv
// Stand-in for the processor core and the reference oscillator.
// Assumes the bench asks for wait or stop with one-cycle request levels.
`timescale 1ns/1ps
module cpm_core_model
  import cpm_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bench requests and core state
  input wire logic req_wait,
  input wire logic req_stop,
  input wire logic cpu_halted,
  // Towards the controller
  output logic ref_tick,
  output logic cpu_wait_instr,
  output logic cpu_stop_instr
);
  // ****************************************************************
  // Reference enable and instruction pulses
  // ****************************************************************
  localparam int REF_MHZ = REF_HZ / 1_000_000;
  logic [6:0] phase;

  // 32 MHz as an enable on pclk: four ticks in five cycles
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      phase <= 7'h00;
      ref_tick <= 1'b0;
    end
    else
    begin
      ref_tick <= (int'(phase) + REF_MHZ >= CLK_MHZ);
      phase <= 7'((int'(phase) + REF_MHZ) % CLK_MHZ);
    end
  end

  // A halted core cannot execute, so requests then are dropped
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cpu_wait_instr <= 1'b0;
      cpu_stop_instr <= 1'b0;
    end
    else
    begin
      cpu_wait_instr <= req_wait & ~cpu_halted;
      cpu_stop_instr <= req_stop & ~cpu_halted;
    end
  end
endmodule // cpm_core_model

// File: sim/cpm_top_tb.sv
// Self-checking bench for the clock and power-mode controller.
// Assumes cpm_core_model drives the reference tick and instructions.
`timescale 1ns/1ps
module cpm_top_tb;
  import cpm_pkg::*;
  // ****************************************************************
  // Signals and counters
  // ****************************************************************
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [AW-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic pready, pslverr, ref_tick, cpu_wait_instr, cpu_stop_instr;
  logic [31:0] prdata;
  logic req_wait = 1'b0;
  logic req_stop = 1'b0;
  logic irq_pending = 1'b0;
  logic kbd_req = 1'b0;
  logic serial_rxd = 1'b1;
  logic xtal32k_clk = 1'b0;
  logic osc1k_clk = 1'b0;
  logic osc1k_q = 1'b0;
  logic [2:0] radio_busy = 3'h0;
  cpm_clk_t clk_en;
  logic [NPERIPH-1:0] periph_clk_en;
  logic wd_en, reg_stby, osc_en, cpu_halted, radio_pwr;
  int n_fail = 0;
  int n_tests = 0;
  int c_ref, c_cpu, c_bus, c_wd, c_1k, cyc, slow_div;
  int c_per [NPERIPH];

  always #12.5 pclk = ~pclk;

  // Slow oscillators, sped up so wake timing fits a short run
  always @(posedge pclk)
  begin
    slow_div <= slow_div + 1;
    if (slow_div % 20 == 19) osc1k_clk <= ~osc1k_clk;
    if (slow_div % 8 == 7) xtal32k_clk <= ~xtal32k_clk;
    osc1k_q <= osc1k_clk;
  end

  // Pulse counters; cleared on the falling edge to avoid races
  always @(posedge pclk)
  begin
    if (ref_tick === 1'b1) c_ref++;
    if (clk_en.cpu_en === 1'b1) c_cpu++;
    if (clk_en.bus_en === 1'b1) c_bus++;
    if (wd_en === 1'b1) c_wd++;
    if (osc1k_clk && !osc1k_q) c_1k++;
    for (int i = 0; i < NPERIPH; i++) if (periph_clk_en[i] === 1'b1) c_per[i]++;
  end
  always @(negedge pclk) cyc++;

  cpm_core_model u_core (.pclk(pclk), .presetn(presetn), .req_wait(req_wait), .req_stop(req_stop),
    .cpu_halted(cpu_halted), .ref_tick(ref_tick), .cpu_wait_instr(cpu_wait_instr),
    .cpu_stop_instr(cpu_stop_instr));

  cpm_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .ref_tick(ref_tick), .cpu_wait_instr(cpu_wait_instr), .cpu_stop_instr(cpu_stop_instr),
    .irq_pending(irq_pending), .keypad_interrupt_unit_req(kbd_req), .serial_rxd(serial_rxd),
    .xtal32k_clk(xtal32k_clk), .osc1k_clk(osc1k_clk), .radio_tx_busy(radio_busy[0]),
    .radio_rx_busy(radio_busy[1]), .radio_cca_busy(radio_busy[2]), .clk_en(clk_en),
    .periph_clk_en(periph_clk_en), .watchdog_monitor_clk_en(wd_en), .regulator_standby(reg_stby),
    .ref_osc_enable(osc_en), .cpu_halted(cpu_halted), .radio_power_en(radio_pwr));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_in(input string what, input int lo, input int hi, input int got);
    n_tests++;
    if (got < lo || got > hi)
    begin
      n_fail++;
      $display("mismatch %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask

  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [AW-1:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 100)
    begin
      k++;
      @(posedge pclk);
    end
    chk("pready", 1, pready);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic measure(input int n);
    @(negedge pclk);
    c_ref = 0;
    c_cpu = 0;
    c_bus = 0;
    c_wd = 0;
    c_1k = 0;
    c_per = '{default: 0};
    repeat (n) @(negedge pclk);
  endtask

  task automatic instr(input logic stop);
    @(posedge pclk);
    req_stop <= stop;
    req_wait <= !stop;
    @(posedge pclk);
    req_stop <= 1'b0;
    req_wait <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    logic [31:0] q;
    logic e;
    logic [AW-1:0] offs [5] = '{CTRL_OFF, GATE_OFF, STAT_OFF, WMOD_OFF, 8'h10};
    logic [31:0] exps [5] = '{32'(CTRL_RST), 32'(GATE_RST), 32'h0, 32'(WMOD_RST), 32'h0};
    for (int i = 0; i < 5; i++)
    begin
      apb(1'b0, offs[i], 32'h0, q, e);
      chk("reset readback", exps[i], q);
      chk("slave error", 32'(i == 4), 32'(e));
    end
    chk("regulator after reset", 0, reg_stby);
    chk("oscillator after reset", 1, osc_en);
    $display("test reset done");
  endtask

  task automatic t_rates();
    measure(400);
    chk_in("cpu rate", c_ref - 1, c_ref + 1, c_cpu);
    chk_in("bus rate", c_cpu / BUS_DIV - 1, c_cpu / BUS_DIV + 1, c_bus);
    wr(GATE_OFF, 32'ha5);
    measure(200);
    for (int i = 0; i < NPERIPH; i++)
      chk_in("peripheral gate", (8'ha5 >> i) & 1 ? c_bus : 0, (8'ha5 >> i) & 1 ? c_bus : 0, c_per[i]);
    wr(GATE_OFF, 32'hff);
    wr(CTRL_OFF, 32'h01);
    measure(1280);
    chk_in("lp cpu rate", c_ref / LP_DIV - 1, c_ref / LP_DIV + 1, c_cpu);
    chk_in("lp bus rate", c_ref / LP_DIV / BUS_DIV - 1, c_ref / LP_DIV / BUS_DIV + 1, c_bus);
    chk("lp regulator", 1, reg_stby);
    wr(CTRL_OFF, 32'h08);
    measure(400);
    chk_in("watchdog on bus", c_bus - 1, c_bus + 1, c_wd);
    wr(CTRL_OFF, 32'h00);
    measure(800);
    chk_in("watchdog on 1k", c_1k - 1, c_1k + 1, c_wd);
    $display("test rates done");
  endtask

  task automatic t_wait(input logic [7:0] ctrl);
    logic [31:0] q;
    logic e;
    int bus_exp;
    wr(CTRL_OFF, 32'(ctrl));
    instr(1'b0);
    chk("halted in wait", 1, cpu_halted);
    apb(1'b0, STAT_OFF, 32'h0, q, e);
    chk("wait state", 1, q[1:0]);
    measure(640);
    bus_exp = ctrl != 0 ? c_ref / (LP_DIV * BUS_DIV) : c_ref / BUS_DIV;
    chk_in("cpu in wait", 0, 0, c_cpu);
    chk_in("bus in wait", bus_exp - 1, bus_exp + 1, c_bus);
    chk("regulator in wait", 32'(ctrl != 0), reg_stby);
    @(posedge pclk);
    irq_pending <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("wait exit", 0, cpu_halted);
    irq_pending <= 1'b0;
    wr(CTRL_OFF, 32'h0);
    $display("test wait done");
  endtask

  task automatic t_stop(input logic [7:0] ctrl, input int kind, input int w, input int p);
    logic [31:0] q;
    logic e;
    int t0;
    wr(CTRL_OFF, 32'(ctrl));
    instr(1'b1);
    t0 = cyc;
    chk("halted in stop", 1, cpu_halted);
    chk("regulator in stop", 1, reg_stby);
    chk("oscillator in stop", ctrl[2], osc_en);
    measure(40);
    chk_in("clocks in stop", 0, 0, c_cpu + c_bus + c_per[0]);
    apb(1'b0, STAT_OFF, 32'h0, q, e);
    chk("stop state", 2, q[1:0]);
    @(posedge pclk);
    if (kind == 0) kbd_req <= 1'b1;
    if (kind == 1) serial_rxd <= 1'b0;
    if (kind != 2) t0 = cyc;
    while (cpu_halted !== 1'b0 && cyc - t0 < 2000) @(posedge pclk);
    kbd_req <= 1'b0;
    serial_rxd <= 1'b1;
    chk_in("wake delay", (w - 1) * p + SETTLE_CYC, (w + 1) * p + SETTLE_CYC + 10, cyc - t0);
    chk("prior run mode", ctrl[0], reg_stby);
    chk("oscillator after wake", 1, osc_en);
    apb(1'b0, STAT_OFF, 32'h0, q, e);
    chk("wake source", 32'(1 << kind), 32'(q[STAT_WSRC_LSB +: WSRC_W]));
    wr(STAT_OFF, 32'h70);
    wr(CTRL_OFF, 32'h0);
    $display("test stop done");
  endtask

  task automatic t_radio();
    for (int i = 0; i < 3; i++)
    begin
      @(posedge pclk);
      radio_busy <= 3'(1 << i);
      repeat (3) @(posedge pclk);
      chk("radio on", 1, radio_pwr);
      radio_busy <= 3'h0;
      repeat (3) @(posedge pclk);
      chk("radio off", 0, radio_pwr);
    end
    $display("test radio done");
  endtask

  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_rates();
    t_wait(8'h00);
    t_wait(8'h02);
    t_stop(8'h45, 0, 0, 0);
    t_stop(8'h80, 1, 0, 0);
    wr(WMOD_OFF, 32'd8);
    t_stop(8'h20, 2, 8, 40);
    wr(WMOD_OFF, 32'd20);
    t_stop(8'h30, 2, 20, 16);
    t_radio();
    results();
  end

  initial
  begin
    repeat (40000) @(posedge pclk);
    n_fail++;
    $display("mismatch run length expected finish seen timeout");
    results();
  end
endmodule // cpm_top_tb
